// *** rtl/stm_pkg.sv ***
// constants and types shared by the split timer block
package stm_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 12;            // apb byte address width
  localparam int unsigned DATA_W = 32;            // apb data width
  localparam int unsigned REG_W  = 8;             // width of every register

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_TCTRL = 10'h088;     // timer_control
  localparam logic [9:0] IDX_TMODE = 10'h089;     // timer_mode_config
  localparam logic [9:0] IDX_T0LO  = 10'h08A;     // timer_zero_low_byte
  localparam logic [9:0] IDX_T1LO  = 10'h08B;     // timer one low byte
  localparam logic [9:0] IDX_T0HI  = 10'h08C;     // timer_zero_high_byte
  localparam logic [9:0] IDX_T1HI  = 10'h08D;     // timer one high byte
  localparam logic [9:0] IDX_CKSEL = 10'h08E;     // clock_select_config

  // ==========================================================
  // reset values
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] TMODE_RST = 8'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CKSEL_RST = 8'h00;

  // ==========================================================
  // timer_control fields
  localparam int unsigned B_T1_FLAG = 7;          // timer_one_overflow_flag
  localparam int unsigned B_T1_RUN  = 6;          // timer_one_run
  localparam int unsigned B_T0_FLAG = 5;          // timer_zero_overflow_flag
  localparam int unsigned B_T0_RUN  = 4;          // timer_zero_run

  // timer_mode_config fields
  localparam int unsigned B_T1_GATE = 7;          // timer one gate enable
  localparam int unsigned B_T1_CSEL = 6;          // timer one count select
  localparam int unsigned B_T1_MODE = 4;          // low bit of mode pair
  localparam int unsigned B_T0_GATE = 3;          // timer_zero_gate_enable
  localparam int unsigned B_T0_CSEL = 2;          // timer_zero_count_select
  localparam int unsigned B_T0_MODE = 0;          // low bit of mode pair

  // clock_select_config fields (1 = undivided tick)
  localparam int unsigned B_T0_DIV1 = 0;
  localparam int unsigned B_T1_DIV1 = 1;

  // ==========================================================
  // timing
  localparam int unsigned PRESCALE  = 12;         // clocks per slow tick
  localparam logic [3:0]  PRE_LAST  = 4'(PRESCALE - 1);

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    STM_MODE_13BIT,
    STM_MODE_16BIT,
    STM_MODE_RELOAD,
    STM_MODE_SPLIT
  } stm_mode_t;

endpackage : stm_pkg

// *** rtl/stm_prescale.sv ***
// divide-by-twelve tick generator for the timers
module stm_prescale
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tick out
  output logic      tick_slow
);
  import stm_pkg::*;

  logic [3:0] cnt_q;                              // position in period

  // ==========================================================
  // counter wraps every PRESCALE clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 4'h0;
    else if (cnt_q == PRE_LAST)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end

  // one pulse per period
  assign tick_slow = (cnt_q == PRE_LAST);

endmodule : stm_prescale

// *** rtl/stm_top.sv ***
// timer zero/one pair with split mode, behind an apb slave
// How it works
// R1: mode three splits timer zero in two
// R2: low byte keeps timer zero's own controls
// R3: low byte counts ticks or pin falls
// R4: high byte counts ticks while timer_one_run
// R5: high byte overflow sets timer one flag
// R6: timer one holds in its own mode three
// R7: split: timer one ignores pin, no flag
// R8: timer one overflow still drives baud tick
// R9: flags set by overflow, writable, cleared on ack
// R10: tick is clock over one or twelve
// R11: counter mode counts sampled pin falls
// R12: run needs run bit and gate clear or pin high
module stm_top
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [stm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [stm_pkg::DATA_W-1:0] pwdata,
  output logic      [stm_pkg::DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  // port pins
  input  wire logic                   t0_count_pin,
  input  wire logic                   t1_count_pin,
  input  wire logic                   ext_irq_zero_pin,
  input  wire logic                   ext_irq_one_pin,
  // interrupt vector acknowledges
  input  wire logic                   t0_vector_ack,
  input  wire logic                   t1_vector_ack,
  // status out
  output logic                        timer_zero_overflow_flag,
  output logic                        timer_one_overflow_flag,
  output logic                        baud_tick
);
  import stm_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] tctrl_q;                            // timer_control
  logic [7:0] tmode_q;                            // timer_mode_config
  logic [7:0] cksel_q;                            // clock_select_config
  logic [7:0] t0lo_q;                             // timer_zero_low_byte
  logic [7:0] t0hi_q;                             // timer_zero_high_byte
  logic [7:0] t1lo_q;                             // timer one low byte
  logic [7:0] t1hi_q;                             // timer one high byte
  logic       pin0_q;                             // last count pin zero
  logic       pin1_q;                             // last count pin one
  logic       baud_q;                             // baud pulse
  logic [DATA_W-1:0] rdata_q;                     // read data
  logic       ready_q;                            // access ready
  logic       err_q;                              // access error

  // ==========================================================
  // combinational controls
  logic       tick_slow;                          // divided tick
  logic       tick0, tick1;                       // per timer ticks
  logic       fall0, fall1;                       // pin falling edges
  logic       split;                              // timer zero in mode 3
  stm_mode_t  mode0, mode1;                       // decoded modes
  logic       run0, run1;                         // gated run terms
  logic       step0, step1, step0hi;              // increment strobes
  logic [16:0] nxt0, nxt1;                        // {ovf, hi, lo}
  logic       ovf0, ovf1, ovf0hi;                 // overflow events
  logic       set_f0, set_f1;                     // flag set requests
  logic       acc, wr;                            // access phase, write
  logic [2:0] sel;                                // decoded register

  // ==========================================================
  // decode a byte address to a register number, 0 = unmapped
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'b00)
      reg_sel = 3'h0;
    else if (idx == IDX_TCTRL)
      reg_sel = 3'h1;
    else if (idx == IDX_TMODE)
      reg_sel = 3'h2;
    else if (idx == IDX_T0LO)
      reg_sel = 3'h3;
    else if (idx == IDX_T1LO)
      reg_sel = 3'h4;
    else if (idx == IDX_T0HI)
      reg_sel = 3'h5;
    else if (idx == IDX_T1HI)
      reg_sel = 3'h6;
    else if (idx == IDX_CKSEL)
      reg_sel = 3'h7;
    else
      reg_sel = 3'h0;
  endfunction : reg_sel

  // ==========================================================
  // one increment of a counter pair in modes 0 to 2;
  // the split low byte uses the plain 8-bit branch
  function automatic logic [16:0] timer_step(input stm_mode_t m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    case (m)
      STM_MODE_13BIT:
        // 13 bits, upper low-byte bits left alone
        timer_step = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
      STM_MODE_16BIT:
        timer_step = {&{hi, lo}, c16};
      STM_MODE_RELOAD:
        // wrap reloads low byte from high byte
        timer_step = {&lo, hi, (&lo) ? hi : lo + 8'h01};
      default:
        timer_step = {&lo, hi, lo + 8'h01};
    endcase
  endfunction : timer_step

  // ==========================================================
  // slow tick source
  stm_prescale u_prescale
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_slow (tick_slow)
  );

  // ==========================================================
  // run, source and overflow decisions
  always_comb
  begin
    mode0  = stm_mode_t'(tmode_q[B_T0_MODE +: 2]);
    mode1  = stm_mode_t'(tmode_q[B_T1_MODE +: 2]);
    split  = (mode0 == STM_MODE_SPLIT);
    // R10 tick divider select
    tick0  = cksel_q[B_T0_DIV1] | tick_slow;
    tick1  = cksel_q[B_T1_DIV1] | tick_slow;
    // R11 sampled falling edges
    fall0  = pin0_q & ~t0_count_pin;
    fall1  = pin1_q & ~t1_count_pin;
    // R12 run and gate
    run0   = tctrl_q[B_T0_RUN] & (~tmode_q[B_T0_GATE] | ext_irq_zero_pin);
    run1   = tctrl_q[B_T1_RUN] & (~tmode_q[B_T1_GATE] | ext_irq_one_pin);
    // R2 R3 low byte keeps own controls
    step0  = run0 & (tmode_q[B_T0_CSEL] ? fall0 : tick0);
    // R4 high byte: ticks only, gated by timer_one_run
    step0hi = split & tctrl_q[B_T1_RUN] & tick0;
    // R6 R7 timer one: held in own mode 3, no pin in split
    if (mode1 == STM_MODE_SPLIT)
      step1 = 1'b0;
    else if (split)
      step1 = tick1;
    else
      step1 = run1 & (tmode_q[B_T1_CSEL] ? fall1 : tick1);
    // R1 split low byte steps as a lone 8-bit counter
    nxt0   = timer_step(mode0, t0lo_q, t0hi_q);
    nxt1   = timer_step(mode1, t1lo_q, t1hi_q);
    ovf0   = step0 & nxt0[16];
    ovf0hi = step0hi & (&t0hi_q);
    ovf1   = step1 & nxt1[16];
    // R5 R7 split: high byte owns timer one flag
    set_f0 = ovf0;
    set_f1 = split ? ovf0hi : ovf1;
    // apb access decode
    acc    = psel & penable & ready_q;
    wr     = acc & pwrite;
    sel    = reg_sel(paddr);
  end

  // ==========================================================
  // edge detector history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
    end
    else
    begin
      pin0_q <= t0_count_pin;
      pin1_q <= t1_count_pin;
    end
  end

  // ==========================================================
  // timer_control: run bits, flags, stored external bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tctrl_q <= TCTRL_RST;
    else
    begin
      if (wr && sel == 3'h1)
        tctrl_q <= pwdata[7:0];
      // R9 flags: hardware set beats write and ack
      if (set_f0)
        tctrl_q[B_T0_FLAG] <= 1'b1;
      else if (wr && sel == 3'h1)
        tctrl_q[B_T0_FLAG] <= pwdata[B_T0_FLAG];
      else if (t0_vector_ack)
        tctrl_q[B_T0_FLAG] <= 1'b0;
      // R9 same for timer one flag
      if (set_f1)
        tctrl_q[B_T1_FLAG] <= 1'b1;
      else if (wr && sel == 3'h1)
        tctrl_q[B_T1_FLAG] <= pwdata[B_T1_FLAG];
      else if (t1_vector_ack)
        tctrl_q[B_T1_FLAG] <= 1'b0;
    end
  end

  // ==========================================================
  // mode and clock select configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmode_q <= TMODE_RST;
      cksel_q <= CKSEL_RST;
    end
    else
    begin
      if (wr && sel == 3'h2)
        tmode_q <= pwdata[7:0];
      if (wr && sel == 3'h7)
        cksel_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // timer zero bytes; a software write wins over a count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t0lo_q <= CNT_RST;
      t0hi_q <= CNT_RST;
    end
    else
    begin
      if (wr && sel == 3'h3)
        t0lo_q <= pwdata[7:0];
      else if (step0)
        t0lo_q <= nxt0[7:0];
      if (wr && sel == 3'h5)
        t0hi_q <= pwdata[7:0];
      // R1 R4 split high byte counts on its own
      else if (step0hi)
        t0hi_q <= t0hi_q + 8'h01;
      else if (step0 && !split)
        t0hi_q <= nxt0[15:8];
    end
  end

  // ==========================================================
  // timer one bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t1lo_q <= CNT_RST;
      t1hi_q <= CNT_RST;
    end
    else
    begin
      if (wr && sel == 3'h4)
        t1lo_q <= pwdata[7:0];
      else if (step1)
        t1lo_q <= nxt1[7:0];
      if (wr && sel == 3'h6)
        t1hi_q <= pwdata[7:0];
      else if (step1)
        t1hi_q <= nxt1[15:8];
    end
  end

  // ==========================================================
  // R8 baud pulse follows every timer one overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_q <= 1'b0;
    else
      baud_q <= ovf1;
  end

  // ==========================================================
  // apb answer: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ready_q <= psel & ~penable & ~ready_q;
      // error flop rises only together with ready
      err_q   <= psel & ~penable & ~ready_q & (sel == 3'h0);
      if (psel && !penable)
      begin
        // narrow register in low bits, rest reads zero
        case (sel)
          3'h1:    rdata_q <= {24'h000000, tctrl_q};
          3'h2:    rdata_q <= {24'h000000, tmode_q};
          3'h3:    rdata_q <= {24'h000000, t0lo_q};
          3'h4:    rdata_q <= {24'h000000, t1lo_q};
          3'h5:    rdata_q <= {24'h000000, t0hi_q};
          3'h6:    rdata_q <= {24'h000000, t1hi_q};
          3'h7:    rdata_q <= {24'h000000, cksel_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign prdata                   = rdata_q;
  assign pready                   = ready_q;
  assign pslverr                  = err_q;
  assign timer_zero_overflow_flag = tctrl_q[B_T0_FLAG];
  assign timer_one_overflow_flag  = tctrl_q[B_T1_FLAG];
  assign baud_tick                = baud_q;

endmodule : stm_top

// *** verification/stm_top_properties.sv ***
// port checker for the split timer block
module stm_top_properties
  import stm_pkg::*;
(
  // clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // apb slave side
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [stm_pkg::ADDR_W-1:0]  paddr,
  input wire logic [stm_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // acknowledges and flags
  input wire logic                        t0_vector_ack,
  input wire logic                        t1_vector_ack,
  input wire logic                        timer_zero_overflow_flag,
  input wire logic                        timer_one_overflow_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // helper decode of the bus
  logic setup;  // setup cycle
  logic bad;    // unmapped or misaligned
  logic tcw;    // completed write to timer_control
  assign setup = psel && !penable;
  assign bad = (paddr[1:0] != 2'h0) || (paddr < 12'h220) || (paddr > 12'h238);
  assign tcw = psel && penable && pready && pwrite && (paddr == 12'h220);
  // ==========================================================
  // bus timing
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  refused_addr_a: assert property (setup && bad |=> pslverr && prdata == 0)
    else $error("bad address not refused");
  mapped_addr_a: assert property (setup && !bad |=>
    !pslverr && prdata[31:8] == 0) else $error("mapped access refused");
  // ==========================================================
  // flags fall only by acknowledge or software write
  flag_zero_clear_a: assert property ($fell(timer_zero_overflow_flag) |->
    $past(t0_vector_ack) || $past(tcw)) else $error("flag zero cleared alone");
  flag_one_clear_a: assert property ($fell(timer_one_overflow_flag) |->
    $past(t1_vector_ack) || $past(tcw)) else $error("flag one cleared alone");
endmodule : stm_top_properties

bind stm_top stm_top_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .t0_vector_ack(t0_vector_ack), .t1_vector_ack(t1_vector_ack),
  .timer_zero_overflow_flag(timer_zero_overflow_flag),
  .timer_one_overflow_flag(timer_one_overflow_flag));

// *** verification/stm_top_tb.sv ***
// self-checking bench for the split timer block
module stm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stm_pkg::*;
  // ==========================================================
  // signals
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic              pready, pslverr, tick, f0, f1;
  logic              c0 = 1, c1 = 1, g0 = 0, g1 = 0, ak0 = 0, ak1 = 0;
  logic [7:0]        v;
  logic              e;
  int                err_total = 0, total_checks = 0, bt;
  // byte addresses, four times the index
  localparam logic [11:0] TC = {IDX_TCTRL, 2'b00}, TM = {IDX_TMODE, 2'b00};
  localparam logic [11:0] T0L = {IDX_T0LO, 2'b00}, T0H = {IDX_T0HI, 2'b00};
  localparam logic [11:0] T1L = {IDX_T1LO, 2'b00}, T1H = {IDX_T1HI, 2'b00};
  localparam logic [11:0] CK = {IDX_CKSEL, 2'b00};
  // ==========================================================
  stm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t0_count_pin(c0),
    .t1_count_pin(c1), .ext_irq_zero_pin(g0), .ext_irq_one_pin(g1),
    .t0_vector_ack(ak0), .t1_vector_ack(ak1),
    .timer_zero_overflow_flag(f0), .timer_one_overflow_flag(f1),
    .baud_tick(tick));
  // clock at 100 MHz
  initial forever #5 pclk = ~pclk;
  // ==========================================================
  // compare and tally
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic       wr,
                     input logic [11:0] a,
                     input logic [7:0]  d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    v = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read and compare one register
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(v, exp);
  endtask : rd
  // wait cycles, counting baud pulses
  task automatic run(input int n);
    bt = 0;
    repeat (n)
    begin
      @(posedge pclk);
      if (tick === 1'b1) bt++;
    end
  endtask : run
  // one falling edge on the timer zero count pin
  task automatic fall0();
    c0 <= 1'b0;
    c1 <= ~c1;
    run(2);
    c0 <= 1'b1;
    run(2);
  endtask : fall0
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // watchdog
  initial
  begin
    repeat (8000) @(posedge pclk);
    err_total++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused addresses
    rd(TC, TCTRL_RST);
    rd(TM, TMODE_RST);
    rd(CK, CKSEL_RST);
    apb(1'b1, TC, 8'h0F);
    rd(TC, 8'h0F);
    rd(12'h300, 8'h00);
    check({7'h0, e}, 8'h01);
    rd(12'h221, 8'h00);
    check({7'h0, e}, 8'h01);
    apb(1'b1, TC, 8'h00);
    $display("test registers done");
    // timer one holds in own mode three
    apb(1'b1, CK, 8'h03);
    apb(1'b1, T1H, 8'hFF);
    apb(1'b1, T1L, 8'hFF);
    apb(1'b1, TM, 8'h33);
    run(30);
    check(bt[7:0], 8'h00);
    apb(1'b1, TM, 8'h23);
    run(20);
    check({7'h0, bt >= 18}, 8'h01);
    check({7'h0, f1}, 8'h00);
    apb(1'b1, TM, 8'h33);
    apb(1'b1, T1H, 8'hFF);
    apb(1'b1, T1L, 8'hF0);
    apb(1'b1, TM, 8'h13);
    run(40);
    check(bt[7:0], 8'h01);
    // thirteen bit mode, pin select ignored
    apb(1'b1, TM, 8'h33);
    apb(1'b1, T1H, 8'hFF);
    apb(1'b1, T1L, 8'h10);
    apb(1'b1, TM, 8'h43);
    run(40);
    check(bt[7:0], 8'h01);
    check({7'h0, f1}, 8'h00);
    $display("test timer one done");
    // high byte sets timer one flag
    apb(1'b1, T0L, 8'hF0);
    apb(1'b1, T0H, 8'hFA);
    apb(1'b1, TC, 8'h40);
    run(12);
    check({6'h0, f1, f0}, 8'h02);
    rd(T0L, 8'hF0);
    // high byte stops with run bit
    apb(1'b1, TC, 8'h80);
    apb(1'b0, T0H, 8'h00);
    check({7'h0, v < 8'h20}, 8'h01);
    run(20);
    rd(T0H, v);
    ak1 <= 1'b1;
    run(1);
    ak1 <= 1'b0;
    run(1);
    check({7'h0, f1}, 8'h00);
    $display("test high byte done");
    // low byte ignores tick in pin mode
    apb(1'b1, TC, 8'h00);
    apb(1'b1, TM, 8'h27);
    apb(1'b1, T0L, 8'hFE);
    apb(1'b1, TC, 8'h10);
    run(10);
    rd(T0L, 8'hFE);
    // two pin falls wrap low byte
    fall0();
    fall0();
    rd(T0L, 8'h00);
    check({7'h0, f0}, 8'h01);
    ak0 <= 1'b1;
    run(1);
    ak0 <= 1'b0;
    run(1);
    check({7'h0, f0}, 8'h00);
    $display("test low byte done");
    apb(1'b1, TM, 8'h2B);
    apb(1'b1, T0L, 8'h00);
    apb(1'b1, TC, 8'h10);
    run(30);
    rd(T0L, 8'h00);
    g0 <= 1'b1;
    run(30);
    apb(1'b0, T0L, 8'h00);
    check({7'h0, v > 8'h10}, 8'h01);
    $display("test gate done");
    apb(1'b1, TC, 8'h00);
    apb(1'b1, CK, 8'h02);
    apb(1'b1, TM, 8'h23);
    apb(1'b1, T0L, 8'h00);
    apb(1'b1, TC, 8'h10);
    run(120);
    apb(1'b1, TC, 8'h00);
    apb(1'b0, T0L, 8'h00);
    check({7'h0, v >= 8'h09 && v <= 8'h0B}, 8'h01);
    $display("test prescale done");
    test_done();
  end
endmodule : stm_top_tb
